// ### hdl/tbr_pkg.sv
// constants and types for the trace buffer item readout
// Function
// - data read shows oldest item, then advances
// - writes to data read register ignored
// - item is 18 bits, resets to zero
// - wide entities span consecutive items, repeated reads
// - complete item1: cycle count, status 17-19
// - complete item2: status, destination register, written
// - complete item3: exception, load/store, enables, data
// - complete items4-5: data, address or instruction
// - complete items6-8: address, program counter
// - branch item: tag 00, count, leftmost outcomes
// - zero-branch item emitted on flush, reader discards
// - counter record: two items tagged 01
// - read limit is sampled count in status
// - level selects item format
package tbr_pkg;

  localparam int ITEM_W     = 18;
  localparam int FIFO_DEPTH = 16;
  localparam int CTRL_W     = 22;
  localparam int SEQ_MAX    = 8;
  localparam int BR_MAX     = 12;

  // debug port register select codes
  localparam logic [7:0] CMD_TRACE_CONTROL = 8'h61;
  localparam logic [7:0] CMD_TRACE_COMMAND = 8'h62;
  localparam logic [7:0] CMD_TRACE_STATUS  = 8'h63;
  localparam logic [7:0] CMD_TRACE_READ    = 8'h66;

  // trace command bits
  localparam int TCMD_CLEAR  = 3;
  localparam int TCMD_START  = 2;
  localparam int TCMD_STOP   = 1;
  localparam int TCMD_SAMPLE = 0;

  // trace control and status fields
  localparam int CTRL_LEVEL_LO = 4;
  localparam int STAT_STARTED  = 17;
  localparam int STAT_OVERFLOW = 16;

  // item tags in bits 17:16
  localparam logic [1:0] TAG_BRANCH = 2'h0;
  localparam logic [1:0] TAG_PC     = 2'h1;

  // reset values
  localparam logic [ITEM_W-1:0] ITEM_RESET  = 18'h00000;
  localparam logic [CTRL_W-1:0] CTRL_RESET  = 22'h000000;
  localparam logic [15:0]       COUNT_RESET = 16'h0000;

  typedef enum logic [1:0]
  {
    TBR_LVL_COMPLETE = 2'b00,
    TBR_LVL_FLOW     = 2'b01,
    TBR_LVL_EVENT    = 2'b10,
    TBR_LVL_FLOW_CYC = 2'b11
  } tbr_level_t;

endpackage

// ### hdl/tbr_fifo.sv
// flip-flop fifo with valid/ready on both sides and a synchronous flush
module tbr_fifo
#(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
)
(
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     rst_n,
  input  wire logic                     flush,
  // fill side
  input  wire logic                     in_valid,
  output logic                          in_ready,
  input  wire logic [WIDTH-1:0]         in_data,
  // drain side
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic      [WIDTH-1:0]         out_data,
  // occupancy
  output logic      [$clog2(DEPTH):0]   count
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             do_push;
  logic             do_pop;

  always_comb
  begin
    in_ready    = (count != DEPTH[AW:0]);
    out_valid   = (count != '0);
    out_data    = mem[rd_ptr];
    do_push     = in_valid && in_ready;
    do_pop      = out_valid && out_ready;
    next_wr_ptr = wr_ptr + AW'(do_push);
    next_rd_ptr = rd_ptr + AW'(do_pop);
    next_count  = count + (AW+1)'(do_push) - (AW+1)'(do_pop);
    if (flush)
    begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count  = '0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // storage has no reset; only written entries are ever read
  always_ff @(posedge clk_sys)
  begin
    if (do_push && !flush)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule

// ### hdl/tbr_readout.sv
// trace buffer: item packing, 16-item buffer and debug port readout
module tbr_readout
(
  // clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      rst_n,
  // debug register port
  input  wire logic [7:0]                dbg_cmd,
  input  wire logic                      dbg_rd,
  input  wire logic                      dbg_wr,
  input  wire logic [tbr_pkg::CTRL_W-1:0] dbg_wdata,
  output logic      [tbr_pkg::ITEM_W-1:0] dbg_rdata,
  // per-instruction trace from the pipeline
  input  wire logic                      trc_retire,
  input  wire logic [14:0]               trc_cycles,
  input  wire logic [31:0]               trc_msr,
  input  wire logic [4:0]                trc_dreg,
  input  wire logic                      trc_dreg_wr,
  input  wire logic [4:0]                trc_exc_kind,
  input  wire logic                      trc_exc_taken,
  input  wire logic                      trc_load,
  input  wire logic                      trc_store,
  input  wire logic [3:0]                trc_byte_en,
  input  wire logic [31:0]               trc_data,
  input  wire logic [31:0]               trc_addr,
  input  wire logic [31:0]               trc_pc,
  // program flow events from the pipeline
  input  wire logic                      trc_branch,
  input  wire logic                      trc_taken,
  input  wire logic                      trc_pc_save,
  input  wire logic                      trc_flush,
  input  wire logic                      trc_cyc_ovf,
  output logic                           trc_ready,
  // trace state
  output logic                           trace_started
);
  import tbr_pkg::*;

  localparam int CW = $clog2(FIFO_DEPTH) + 1;

  // control and status state
  logic [CTRL_W-1:0] ctrl;
  logic [CTRL_W-1:0] next_ctrl;
  logic              started;
  logic              next_started;
  logic              overflow;
  logic              next_overflow;
  logic [15:0]       sampled;
  logic [15:0]       next_sampled;
  logic [ITEM_W-1:0] rdata;
  logic [ITEM_W-1:0] next_rdata;
  tbr_level_t        level;

  // item sequencer and branch accumulator
  logic [ITEM_W-1:0] seq_item [SEQ_MAX];
  logic [ITEM_W-1:0] next_seq_item [SEQ_MAX];
  logic [3:0]        seq_len;
  logic [3:0]        next_seq_len;
  logic [3:0]        seq_idx;
  logic [3:0]        next_seq_idx;
  logic [3:0]        br_cnt;
  logic [3:0]        next_br_cnt;
  logic [11:0]       br_bits;
  logic [11:0]       next_br_bits;
  logic [11:0]       br_add;
  logic [ITEM_W-1:0] br_item;

  // buffer handshakes
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic [ITEM_W-1:0] fifo_out_data;
  logic [CW-1:0]     fifo_count;
  logic              busy;
  logic              accept;
  logic              push;
  logic              pop;
  logic              cmd_wr;
  logic              clear;

  assign level         = tbr_level_t'(ctrl[CTRL_LEVEL_LO+1:CTRL_LEVEL_LO]);
  assign busy          = (seq_idx != seq_len);
  assign push          = busy && fifo_in_ready;
  // the pipeline stalls while a record drains in; a full buffer takes nothing more
  assign accept        = started && !busy && fifo_in_ready;
  assign trc_ready     = accept;
  assign trace_started = started;
  assign cmd_wr        = dbg_wr && (dbg_cmd == CMD_TRACE_COMMAND);
  assign clear         = cmd_wr && dbg_wdata[TCMD_CLEAR];
  // a pop happens only when an item exists, so an empty read leaves pointers alone
  assign pop           = dbg_rd && (dbg_cmd == CMD_TRACE_READ) && fifo_out_valid;
  assign dbg_rdata     = rdata;

  tbr_fifo
  #(
    .WIDTH (ITEM_W),
    .DEPTH (FIFO_DEPTH)
  )
  u_fifo
  (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .flush     (clear),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (seq_item[seq_idx[2:0]]),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out_data),
    .count     (fifo_count)
  );

  // register port: control, command, status and readout
  always_comb
  begin
    next_ctrl     = ctrl;
    next_started  = started;
    next_overflow = overflow;
    next_sampled  = sampled;
    next_rdata    = rdata;
    if (dbg_wr && (dbg_cmd == CMD_TRACE_CONTROL))
    begin
      next_ctrl = dbg_wdata;
    end
    // writes addressed to the data read register match no case and change nothing
    if (cmd_wr)
    begin
      if (dbg_wdata[TCMD_CLEAR])
      begin
        next_overflow = 1'b0;
        next_sampled  = COUNT_RESET;
      end
      if (dbg_wdata[TCMD_SAMPLE])
      begin
        next_sampled = 16'(fifo_count);
      end
      if (dbg_wdata[TCMD_START])
      begin
        next_started = 1'b1;
      end
      if (dbg_wdata[TCMD_STOP])
      begin
        next_started = 1'b0;
      end
    end
    // trace stops by itself once the buffer is full
    if (started && !fifo_in_ready)
    begin
      next_started = 1'b0;
    end
    // overflow event wins over a clear in the same cycle
    if (started && trc_cyc_ovf)
    begin
      next_overflow = 1'b1;
    end
    if (dbg_rd)
    begin
      case (dbg_cmd)
        CMD_TRACE_STATUS:
        begin
          next_rdata = {started, overflow, sampled};
        end
        CMD_TRACE_READ:
        begin
          // empty read keeps the last value; contents are undefined to the reader
          if (fifo_out_valid)
          begin
            next_rdata = fifo_out_data;
          end
        end
        default:
        begin
          next_rdata = ITEM_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      ctrl     <= CTRL_RESET;
      started  <= 1'b0;
      overflow <= 1'b0;
      sampled  <= COUNT_RESET;
      rdata    <= ITEM_RESET;
    end
    else
    begin
      ctrl     <= next_ctrl;
      started  <= next_started;
      overflow <= next_overflow;
      sampled  <= next_sampled;
      rdata    <= next_rdata;
    end
  end

  // branch outcomes fill from the left, so the first branch is bit 11
  always_comb
  begin
    br_add  = br_bits;
    br_add[4'd11 - br_cnt] = trc_taken;
    br_item = {TAG_BRANCH, br_cnt, br_bits};
  end

  // packing of trace entities into items
  always_comb
  begin
    next_seq_item = seq_item;
    next_seq_len  = seq_len;
    next_seq_idx  = seq_idx;
    next_br_cnt   = br_cnt;
    next_br_bits  = br_bits;
    // one item leaves per cycle; the reader collects them one read each
    if (push)
    begin
      next_seq_idx = seq_idx + 4'd1;
    end
    if (accept)
    begin
      case (level)
        TBR_LVL_COMPLETE:
        begin
          if (trc_retire)
          begin
            next_seq_item[0] = {trc_cycles, trc_msr[14:12]};
            next_seq_item[1] = {trc_msr[11:0], trc_dreg, trc_dreg_wr};
            next_seq_item[2] = {trc_exc_kind, trc_exc_taken, trc_load, trc_store,
                                trc_byte_en, trc_data[31:26]};
            next_seq_item[3] = trc_data[25:8];
            next_seq_item[4] = {trc_data[7:0], trc_addr[31:22]};
            next_seq_item[5] = trc_addr[21:4];
            next_seq_item[6] = {trc_addr[3:0], trc_pc[31:18]};
            next_seq_item[7] = trc_pc[17:0];
            next_seq_len     = 4'd8;
            next_seq_idx     = 4'd0;
          end
        end
        TBR_LVL_FLOW, TBR_LVL_FLOW_CYC:
        begin
          if (trc_pc_save)
          begin
            // pending branches go out before the new counter value
            if (br_cnt != 4'd0)
            begin
              next_seq_item[0] = br_item;
              next_seq_item[1] = {TAG_PC, trc_pc[31:16]};
              next_seq_item[2] = {TAG_PC, trc_pc[15:0]};
              next_seq_len     = 4'd3;
            end
            else
            begin
              next_seq_item[0] = {TAG_PC, trc_pc[31:16]};
              next_seq_item[1] = {TAG_PC, trc_pc[15:0]};
              next_seq_len     = 4'd2;
            end
            next_seq_idx = 4'd0;
            next_br_cnt  = 4'd0;
            next_br_bits = 12'h000;
          end
          else if (trc_flush)
          begin
            // may carry zero branches; the reader drops such items
            next_seq_item[0] = br_item;
            next_seq_len     = 4'd1;
            next_seq_idx     = 4'd0;
            next_br_cnt      = 4'd0;
            next_br_bits     = 12'h000;
          end
          else if (trc_branch)
          begin
            if (br_cnt == 4'(BR_MAX - 1))
            begin
              next_seq_item[0] = {TAG_BRANCH, 4'(BR_MAX), br_add};
              next_seq_len     = 4'd1;
              next_seq_idx     = 4'd0;
              next_br_cnt      = 4'd0;
              next_br_bits     = 12'h000;
            end
            else
            begin
              next_br_cnt  = br_cnt + 4'd1;
              next_br_bits = br_add;
            end
          end
        end
        default:
        begin
          // event formats are not generated by this block
          next_seq_len = seq_len;
        end
      endcase
    end
    if (clear)
    begin
      next_seq_len = 4'd0;
      next_seq_idx = 4'd0;
      next_br_cnt  = 4'd0;
      next_br_bits = 12'h000;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      seq_len <= 4'd0;
      seq_idx <= 4'd0;
      br_cnt  <= 4'd0;
      br_bits <= 12'h000;
      for (int i = 0; i < SEQ_MAX; i++)
      begin
        seq_item[i] <= ITEM_RESET;
      end
    end
    else
    begin
      seq_len  <= next_seq_len;
      seq_idx  <= next_seq_idx;
      br_cnt   <= next_br_cnt;
      br_bits  <= next_br_bits;
      seq_item <= next_seq_item;
    end
  end

endmodule

// ### bench/tbr_monitor.sv
// port checker for the trace readout, bound to its top
module tbr_monitor
(
  // clock and reset
  input wire logic                       clk_sys,
  input wire logic                       rst_n,
  // debug register port
  input wire logic [7:0]                 dbg_cmd,
  input wire logic                       dbg_rd,
  input wire logic                       dbg_wr,
  input wire logic [tbr_pkg::CTRL_W-1:0] dbg_wdata,
  input wire logic [tbr_pkg::ITEM_W-1:0] dbg_rdata,
  // trace side
  input wire logic                       trc_retire,
  input wire logic                       trc_branch,
  input wire logic                       trc_pc_save,
  input wire logic                       trc_flush,
  input wire logic                       trc_ready,
  input wire logic                       trace_started
);
  import tbr_pkg::*;
  logic [1:0] lvl;
  logic [1:0] next_lvl;
  // shadow of the level, so record lengths can be judged
  always_comb
  begin
    next_lvl = lvl;
    if (dbg_wr && dbg_cmd == CMD_TRACE_CONTROL)
    begin
      next_lvl = dbg_wdata[CTRL_LEVEL_LO +: 2];
    end
  end
  always_ff @(posedge clk_sys)
  begin
    lvl <= rst_n ? next_lvl : 2'h0;
  end
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  chk_reset_zero: assert property (disable iff (1'b0) !rst_n |=>
    dbg_rdata == 18'h00000 && !trc_ready && !trace_started) else $error("reset state wrong");
  chk_rdata_hold: assert property (!dbg_rd |=> $stable(dbg_rdata))
    else $error("read data moved without a read");
  chk_write_ignored: assert property (dbg_wr && !dbg_rd && dbg_cmd == CMD_TRACE_READ
    |=> $stable(dbg_rdata)) else $error("write to data register had effect");
  chk_status_started: assert property (dbg_rd && dbg_cmd == CMD_TRACE_STATUS
    |=> dbg_rdata[17] == $past(trace_started)) else $error("status started bit wrong");
  chk_start_cause: assert property ($rose(trace_started) |->
    $past(dbg_wr && dbg_cmd == CMD_TRACE_COMMAND && dbg_wdata[TCMD_START]))
    else $error("trace started without start command");
  chk_record_len: assert property (lvl == 2'h0 && trc_ready && trc_retire
    |=> !trc_ready [*8]) else $error("complete record shorter than eight items");
  chk_pc_pair: assert property (lvl[0] && trc_ready && trc_pc_save
    |=> !trc_ready [*2]) else $error("counter record shorter than two items");
  chk_level_gate: assert property (lvl != 2'h0 && trc_ready && trc_retire
    && !trc_pc_save && !trc_flush && !trc_branch && !dbg_wr |=> trc_ready)
    else $error("retire packed outside complete level");
  cov_retire: cover property (lvl == 2'h0 && trc_ready && trc_retire);
  cov_pc_save: cover property (lvl[0] && trc_ready && trc_pc_save);
  cov_status: cover property (dbg_rd && dbg_cmd == CMD_TRACE_STATUS && trace_started);
endmodule

bind tbr_readout tbr_monitor mon
(
  .clk_sys(clk_sys), .rst_n(rst_n), .dbg_cmd(dbg_cmd), .dbg_rd(dbg_rd),
  .dbg_wr(dbg_wr), .dbg_wdata(dbg_wdata), .dbg_rdata(dbg_rdata),
  .trc_retire(trc_retire), .trc_branch(trc_branch), .trc_pc_save(trc_pc_save),
  .trc_flush(trc_flush), .trc_ready(trc_ready), .trace_started(trace_started)
);

// ### bench/tbr_dbg_host.sv
// debug module model issuing register accesses
module tbr_dbg_host
(
  // clock
  input wire logic                       clk_sys,
  // register port
  output logic [7:0]                     dbg_cmd,
  output logic                           dbg_rd,
  output logic                           dbg_wr,
  output logic [tbr_pkg::CTRL_W-1:0]     dbg_wdata,
  input wire logic [tbr_pkg::ITEM_W-1:0] dbg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import tbr_pkg::*;
  int gap = 0;
  initial
  begin
    dbg_cmd = 8'h00;
    dbg_rd = 1'b0;
    dbg_wr = 1'b0;
    dbg_wdata = 22'h000000;
  end
  // one access; command and data lines released to inverted values, strobes to zero, so stale data never looks valid
  task automatic access(input logic [7:0] cmd, input logic rd, input logic [21:0] wd,
                        output logic [17:0] q);
    repeat (gap) @(negedge clk_sys);
    @(negedge clk_sys);
    {dbg_cmd, dbg_rd, dbg_wr, dbg_wdata} = {cmd, rd, !rd, wd};
    @(negedge clk_sys);
    {dbg_cmd, dbg_rd, dbg_wr, dbg_wdata} = {~cmd, 1'b0, 1'b0, ~wd};
    q = dbg_rdata;
  endtask
  // sample, read status, then pop exactly the sampled count
  task automatic fetch(input logic flow, output logic [17:0] st, output logic [17:0] q[$]);
    logic [17:0] v;
    q = {};
    access(CMD_TRACE_COMMAND, 1'b0, 22'h000001, v);
    access(CMD_TRACE_STATUS, 1'b1, 22'h000000, st);
    repeat (st[15:0])
    begin
      access(CMD_TRACE_READ, 1'b1, 22'h000000, v);
      if (!flow || v[17:12] != 6'h00)
      begin
        q.push_back(v);
      end
    end
  endtask
endmodule

// ### bench/tbr_readout_bench.sv
// self-checking bench for the trace buffer readout
module tbr_readout_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import tbr_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] dbg_cmd;
  logic dbg_rd, dbg_wr;
  logic [CTRL_W-1:0] dbg_wdata;
  logic [ITEM_W-1:0] dbg_rdata;
  logic trc_retire = 0, trc_dreg_wr, trc_exc_taken, trc_load, trc_store, trc_branch = 0;
  logic trc_taken = 0, trc_pc_save = 0, trc_flush = 0, trc_cyc_ovf = 0, trc_ready, trace_started;
  logic [14:0] trc_cycles;
  logic [31:0] trc_msr, trc_data, trc_addr, trc_pc;
  logic [4:0] trc_dreg, trc_exc_kind;
  logic [3:0] trc_byte_en;
  int n_fail = 0;
  int num_checks = 0;
  logic [17:0] st, v, q[$], e[$];
  // rows: branch count, outcomes, expected item
  logic [33:0] rows [4] = '{{4'h0, 12'h000, 18'h00000}, {4'h3, 12'hA00, 18'h03A00},
                            {4'h5, 12'hC80, 18'h05C80}, {4'hC, 12'hFFF, 18'h0CFFF}};

  tbr_readout dut (.clk_sys(clk_sys), .rst_n(rst_n), .dbg_cmd(dbg_cmd), .dbg_rd(dbg_rd),
    .dbg_wr(dbg_wr), .dbg_wdata(dbg_wdata), .dbg_rdata(dbg_rdata), .trc_retire(trc_retire),
    .trc_cycles(trc_cycles), .trc_msr(trc_msr), .trc_dreg(trc_dreg),
    .trc_dreg_wr(trc_dreg_wr), .trc_exc_kind(trc_exc_kind), .trc_exc_taken(trc_exc_taken),
    .trc_load(trc_load), .trc_store(trc_store), .trc_byte_en(trc_byte_en),
    .trc_data(trc_data), .trc_addr(trc_addr), .trc_pc(trc_pc), .trc_branch(trc_branch),
    .trc_taken(trc_taken), .trc_pc_save(trc_pc_save), .trc_flush(trc_flush),
    .trc_cyc_ovf(trc_cyc_ovf), .trc_ready(trc_ready), .trace_started(trace_started));
  tbr_dbg_host host (.clk_sys(clk_sys), .dbg_cmd(dbg_cmd), .dbg_rd(dbg_rd),
    .dbg_wr(dbg_wr), .dbg_wdata(dbg_wdata), .dbg_rdata(dbg_rdata));

  initial
  begin
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    if (n_fail == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wreg(input logic [7:0] cmd, input logic [21:0] wd);
    host.access(cmd, 1'b0, wd, v);
  endtask

  // strobe order: retire, branch, pc_save, flush; gives up waiting after 40 cycles
  task automatic ev(input logic [3:0] s, input logic tk);
    @(negedge clk_sys);
    for (int i = 0; i < 40 && trc_ready !== 1'b1; i++) @(negedge clk_sys);
    {trc_retire, trc_branch, trc_pc_save, trc_flush, trc_taken} = {s, tk};
    @(negedge clk_sys);
    {trc_retire, trc_branch, trc_pc_save, trc_flush} = 4'h0;
  endtask

  task automatic fields(input logic [31:0] b);
    {trc_cycles, trc_msr, trc_dreg, trc_dreg_wr, trc_exc_kind} = {b[14:0], b, b[4:0], b[5:0]};
    {trc_exc_taken, trc_load, trc_store, trc_byte_en} = b[6:0];
    {trc_data, trc_addr, trc_pc} = {~b, b[15:0], b[31:16], b + 32'h00001234};
  endtask

  // eight items of one record, fields numbered from the msb as on the wire
  task automatic rec;
    e.push_back({trc_cycles, trc_msr[14:12]});
    e.push_back({trc_msr[11:0], trc_dreg, trc_dreg_wr});
    e.push_back({trc_exc_kind, trc_exc_taken, trc_load, trc_store, trc_byte_en,
                 trc_data[31:26]});
    e.push_back(trc_data[25:8]);
    e.push_back({trc_data[7:0], trc_addr[31:22]});
    e.push_back(trc_addr[21:4]);
    e.push_back({trc_addr[3:0], trc_pc[31:18]});
    e.push_back(trc_pc[17:0]);
  endtask

  initial
  begin
    #300000;
    n_fail++;
    close_out();
  end

  initial
  begin
    fields(32'h00000000);
    repeat (12) @(negedge clk_sys);
    rst_n = 1'b1;
    host.fetch(1'b0, st, q);
    check(st, 18'h00000);
    host.access(CMD_TRACE_READ, 1'b1, 22'h000000, v);
    check(v, 18'h00000);
    wreg(CMD_TRACE_CONTROL, 22'h000010);
    wreg(CMD_TRACE_COMMAND, 22'h000004);
    foreach (rows[r])
    begin
      for (int k = 0; k < rows[r][33:30]; k++) ev(4'h4, rows[r][29 - k]);
      if (rows[r][33:30] < 4'hC) ev(4'h1, 1'b0);
      host.fetch(1'b1, st, q);
      check(st, 18'h20001);
      check(18'(q.size()), 18'(rows[r][33:30] != 4'h0));
      if (q.size() > 0) check(q[0], rows[r][17:0]);
    end
    // counter record after two pending branches, with an overflow event
    ev(4'h4, 1'b1);
    ev(4'h4, 1'b0);
    trc_pc = 32'h89ABCDEF;
    ev(4'h2, 1'b0);
    trc_cyc_ovf = 1'b1;
    @(negedge clk_sys);
    trc_cyc_ovf = 1'b0;
    repeat (2) @(negedge clk_sys);
    host.fetch(1'b1, st, q);
    check(st, 18'h30003);
    check(q[0], 18'h02800);
    check(q[1], 18'h189AB);
    check(q[2], 18'h1CDEF);
    wreg(CMD_TRACE_COMMAND, 22'h000008);
    wreg(CMD_TRACE_CONTROL, 22'h000020);
    ev(4'h8, 1'b0);
    ev(4'h4, 1'b1);
    ev(4'h1, 1'b0);
    host.fetch(1'b1, st, q);
    check(st, 18'h20000);
    // two complete records fill the buffer; the third is refused
    wreg(CMD_TRACE_CONTROL, 22'h000000);
    fields(32'h9E3779B9);
    ev(4'h8, 1'b0);
    rec();
    fields(32'h6C8E9CF5);
    ev(4'h8, 1'b0);
    rec();
    ev(4'h8, 1'b0);
    check(18'(trace_started), 18'h00000);
    wreg(CMD_TRACE_READ, 22'h3FFFFF);
    host.gap = 2;
    host.fetch(1'b0, st, q);
    check(st, 18'h00010);
    check(18'(q.size()), 18'h00010);
    foreach (e[i]) check(q[i], e[i]);
    host.access(CMD_TRACE_READ, 1'b1, 22'h000000, v);
    check(v, e[15]);
    rst_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    check(dbg_rdata, 18'h00000);
    rst_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    close_out();
  end
endmodule
